// *** edph_pkg.sv ***
package edph_pkg;

  // ******************************************************************
  // Register map
  // ******************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RX_FILTER = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TX_START = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RX_START = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_HASH_LOW = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_HASH_HIGH = 8'h14;

  // ******************************************************************
  // Fields and reset values
  // ******************************************************************
  localparam int RECEIVE_LOGIC_ENABLE_BIT = 8;
  localparam int HASH_FILTER_ENABLE_BIT = 15;
  localparam int PTR_LSB = 2;
  localparam int HASH_IDX_W = 6;
  localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
  localparam logic [PTR_LSB-1:0] PTR_LOW_ZERO = 2'h0;

  typedef logic [DATA_W-1:PTR_LSB] edph_ptr_t;

endpackage : edph_pkg

// *** edph_hash_mem.sv ***
`timescale 1ns/10ps

// ********************************************************************
// Receive hash filter table, two words of storage
// ********************************************************************
module edph_hash_mem (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic wr_en_in,
  input wire logic wr_high_in,
  input wire logic [edph_pkg::DATA_W-1:0] wr_data_in,
  input wire logic [edph_pkg::HASH_IDX_W-1:0] lookup_index_in,
  output logic [2*edph_pkg::DATA_W-1:0] table_out,
  output logic lookup_bit_out
);
  import edph_pkg::*;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      table_out <= {REG_RESET, REG_RESET};
    end else if (wr_en_in && wr_high_in) begin
      table_out[2*DATA_W-1:DATA_W] <= wr_data_in;
    end else if (wr_en_in) begin
      table_out[DATA_W-1:0] <= wr_data_in;
    end
  end

  // The lookup answer is registered so the filter path has a full cycle.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      lookup_bit_out <= 1'b0;
    end else begin
      lookup_bit_out <= table_out[lookup_index_in];
    end
  end

endmodule : edph_hash_mem

// *** edph_regs.sv ***
`timescale 1ns/10ps

// How it works
// R1: The transmit start pointer keeps bits 31 to 2 writable and reads bits 1 and 0 as zero.
// R2: Software gives both start pointers four-byte aligned addresses.
// R3: Software leaves both start pointers alone while any transfer is in progress.
// R4: A successful transmit overwrites the transmit start pointer with its last descriptor.
// R5: The receive start pointer keeps bits 31 to 2 writable and reads bits 1 and 0 as zero.
// R6: A completed receive packet overwrites the receive start pointer with its last descriptor.
// R7: The low hash word holds 32 writable bits, bytes zero to three of the hash table.
// R8: Software changes the low hash word only with receive or hash filtering disabled.
// R9: The transmit pointer serves transmit only; receive pointer and hash table serve receive only.
// R10: All implemented bits of the pointers and the low hash word clear on reset.
// R11: With receive enabled packets pass as the filter allows; with it clear none pass.
// R12: A high hash word holds bits 63 to 32 and completes the 64-bit table.
// R13: Writes to the two low pointer bits are dropped so they keep reading zero.

module edph_regs (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [edph_pkg::ADDR_W-1:0] addr_in,
  input wire logic [edph_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic tx_done_in,
  input wire logic [edph_pkg::DATA_W-1:0] tx_last_descriptor_in,
  input wire logic rx_done_in,
  input wire logic [edph_pkg::DATA_W-1:0] rx_last_descriptor_in,
  input wire logic rx_hash_valid_in,
  input wire logic [edph_pkg::HASH_IDX_W-1:0] rx_hash_index_in,
  output logic [edph_pkg::DATA_W-1:0] rd_data_out,
  output logic [edph_pkg::DATA_W-1:0] tx_descriptor_start_out,
  output logic [edph_pkg::DATA_W-1:0] rx_descriptor_start_out,
  output logic receive_logic_enable_out,
  output logic hash_filter_enable_out,
  output logic rx_hash_accept_out
);
  import edph_pkg::*;

  // ******************************************************************
  // Address decode
  // ******************************************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  edph_ptr_t tx_first_descriptor_address;
  edph_ptr_t rx_first_descriptor_address;
  logic [2*DATA_W-1:0] hash_filter_bits;
  logic hash_lookup_bit;
  logic hash_valid_d;
  logic wr_tx;
  logic wr_rx;
  logic wr_hash;

  assign wr_tx = wr_en_in && hit(addr_in, OFS_TX_START);
  assign wr_rx = wr_en_in && hit(addr_in, OFS_RX_START);
  assign wr_hash = wr_en_in && (hit(addr_in, OFS_HASH_LOW) || hit(addr_in, OFS_HASH_HIGH));

  // ******************************************************************
  // Control bits
  // ******************************************************************
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      receive_logic_enable_out <= 1'b0;
    end else if (wr_en_in && hit(addr_in, OFS_CONTROL)) begin
      receive_logic_enable_out <= wr_data_in[RECEIVE_LOGIC_ENABLE_BIT];
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      hash_filter_enable_out <= 1'b0;
    end else if (wr_en_in && hit(addr_in, OFS_RX_FILTER)) begin
      hash_filter_enable_out <= wr_data_in[HASH_FILTER_ENABLE_BIT];
    end
  end

  // ******************************************************************
  // Descriptor start pointers
  // ******************************************************************
  // A completion beats a software write in the same cycle: software is not
  // meant to write during activity, and losing the hardware update would
  // leave the DMA restarting from a stale descriptor.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tx_first_descriptor_address <= REG_RESET[DATA_W-1:PTR_LSB]; // R10
    end else if (tx_done_in) begin
      tx_first_descriptor_address <= tx_last_descriptor_in[DATA_W-1:PTR_LSB]; // R4
    end else if (wr_tx) begin
      tx_first_descriptor_address <= wr_data_in[DATA_W-1:PTR_LSB]; // R1 R13
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rx_first_descriptor_address <= REG_RESET[DATA_W-1:PTR_LSB]; // R10
    end else if (rx_done_in) begin
      rx_first_descriptor_address <= rx_last_descriptor_in[DATA_W-1:PTR_LSB]; // R6
    end else if (wr_rx) begin
      rx_first_descriptor_address <= wr_data_in[DATA_W-1:PTR_LSB]; // R5 R13
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tx_descriptor_start_out <= REG_RESET;
    end else if (tx_done_in) begin
      tx_descriptor_start_out <= {tx_last_descriptor_in[DATA_W-1:PTR_LSB], PTR_LOW_ZERO}; // R9
    end else if (wr_tx) begin
      tx_descriptor_start_out <= {wr_data_in[DATA_W-1:PTR_LSB], PTR_LOW_ZERO};
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rx_descriptor_start_out <= REG_RESET;
    end else if (rx_done_in) begin
      rx_descriptor_start_out <= {rx_last_descriptor_in[DATA_W-1:PTR_LSB], PTR_LOW_ZERO}; // R9
    end else if (wr_rx) begin
      rx_descriptor_start_out <= {wr_data_in[DATA_W-1:PTR_LSB], PTR_LOW_ZERO};
    end
  end

  // ******************************************************************
  // Hash filter table
  // ******************************************************************
  edph_hash_mem u_hash (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .wr_en_in(wr_hash), // R7 R12
    .wr_high_in(hit(addr_in, OFS_HASH_HIGH)),
    .wr_data_in(wr_data_in),
    .lookup_index_in(rx_hash_index_in),
    .table_out(hash_filter_bits),
    .lookup_bit_out(hash_lookup_bit)
  );

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      hash_valid_d <= 1'b0;
    end else begin
      hash_valid_d <= rx_hash_valid_in;
    end
  end

  // With hash filtering off and receive enabled every packet passes this stage; other filters
  // live outside the block and may still reject it.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rx_hash_accept_out <= 1'b0;
    end else begin
      rx_hash_accept_out <= hash_valid_d && receive_logic_enable_out
                            && (!hash_filter_enable_out || hash_lookup_bit); // R11
    end
  end

  // ******************************************************************
  // Read port
  // ******************************************************************
  always_ff @(posedge clock_in) begin
    if (rst_in || !rd_en_in) begin
      rd_data_out <= REG_RESET;
    end else if (hit(addr_in, OFS_CONTROL)) begin
      rd_data_out <= REG_RESET | (DATA_W'(receive_logic_enable_out) << RECEIVE_LOGIC_ENABLE_BIT);
    end else if (hit(addr_in, OFS_RX_FILTER)) begin
      rd_data_out <= REG_RESET | (DATA_W'(hash_filter_enable_out) << HASH_FILTER_ENABLE_BIT);
    end else if (hit(addr_in, OFS_TX_START)) begin
      rd_data_out <= {tx_first_descriptor_address, PTR_LOW_ZERO}; // R1
    end else if (hit(addr_in, OFS_RX_START)) begin
      rd_data_out <= {rx_first_descriptor_address, PTR_LOW_ZERO}; // R5
    end else if (hit(addr_in, OFS_HASH_LOW)) begin
      rd_data_out <= hash_filter_bits[DATA_W-1:0]; // R7
    end else if (hit(addr_in, OFS_HASH_HIGH)) begin
      rd_data_out <= hash_filter_bits[2*DATA_W-1:DATA_W]; // R12
    end else begin
      rd_data_out <= REG_RESET;
    end
  end

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  // Transmit start pointer: a write keeps bits 31 to 2, a completion replaces them.
  tx_low_zero_a: assert property ( // R1
    tx_descriptor_start_out[PTR_LSB-1:0] == PTR_LOW_ZERO)
    else $error("transmit pointer low bits not zero");

  tx_write_a: assert property ( // R13
    wr_tx && !tx_done_in |=> tx_descriptor_start_out ==
      {$past(wr_data_in[DATA_W-1:PTR_LSB]), PTR_LOW_ZERO})
    else $error("transmit pointer write not stored with low bits cleared");

  tx_update_a: assert property ( // R4
    tx_done_in |=> tx_descriptor_start_out ==
      {$past(tx_last_descriptor_in[DATA_W-1:PTR_LSB]), PTR_LOW_ZERO})
    else $error("transmit pointer not updated on completion");

  tx_isolation_a: assert property ( // R9
    !tx_done_in && !wr_tx |=> $stable(tx_descriptor_start_out))
    else $error("transmit pointer changed without cause");

  // The answer stands for one cycle only, unless a second read follows at once.
  tx_read_a: assert property ( // R1
    rd_en_in && hit(addr_in, OFS_TX_START)
    |=> rd_data_out == $past(tx_descriptor_start_out)
    ##1 (rd_data_out == REG_RESET || $past(rd_en_in)))
    else $error("transmit pointer read answer wrong");

  // Receive start pointer, the mirror image of the transmit side, except that the read check does not test that the answer drops.
  rx_low_zero_a: assert property ( // R5
    wr_rx && !rx_done_in |=> rx_descriptor_start_out ==
      {$past(wr_data_in[DATA_W-1:PTR_LSB]), PTR_LOW_ZERO})
    else $error("receive pointer write not stored with low bits cleared");

  rx_bits_zero_a: assert property ( // R5
    rx_descriptor_start_out[PTR_LSB-1:0] == PTR_LOW_ZERO)
    else $error("receive pointer low bits not zero");

  rx_update_a: assert property ( // R6
    rx_done_in |=> rx_descriptor_start_out ==
      {$past(rx_last_descriptor_in[DATA_W-1:PTR_LSB]), PTR_LOW_ZERO})
    else $error("receive pointer not updated on completion");

  rx_isolation_a: assert property ( // R9
    !rx_done_in && !wr_rx |=> $stable(rx_descriptor_start_out))
    else $error("receive pointer changed without cause");

  rx_read_a: assert property ( // R5
    rd_en_in && hit(addr_in, OFS_RX_START)
    |=> rd_data_out == $past(rx_descriptor_start_out))
    else $error("receive pointer read answer wrong");

  // Hash table: a write is read back unchanged, and nothing else moves it.
  hash_low_write_a: assert property ( // R7
    wr_en_in && hit(addr_in, OFS_HASH_LOW)
    ##1 rd_en_in && !wr_en_in && hit(addr_in, OFS_HASH_LOW)
    |=> rd_data_out == $past(wr_data_in, 2))
    else $error("low hash word readback mismatch");

  hash_high_write_a: assert property ( // R12
    wr_en_in && hit(addr_in, OFS_HASH_HIGH)
    ##1 rd_en_in && !wr_en_in && hit(addr_in, OFS_HASH_HIGH)
    |=> rd_data_out == $past(wr_data_in, 2))
    else $error("high hash word readback mismatch");

  hash_hold_a: assert property ( // R7
    !wr_hash |=> $stable(hash_filter_bits))
    else $error("hash table changed without a write");

  hash_low_read_a: assert property ( // R7
    rd_en_in && hit(addr_in, OFS_HASH_LOW)
    |=> rd_data_out == $past(hash_filter_bits[DATA_W-1:0]))
    else $error("low hash word read answer wrong");

  hash_high_read_a: assert property ( // R12
    rd_en_in && hit(addr_in, OFS_HASH_HIGH)
    |=> rd_data_out == $past(hash_filter_bits[2*DATA_W-1:DATA_W]))
    else $error("high hash word read answer wrong");

  // Reset checks run while reset is high, so they carry their own disable.
  reset_clear_a: assert property ( // R10
    disable iff (1'b0) rst_in |=> tx_descriptor_start_out == REG_RESET
    && rx_descriptor_start_out == REG_RESET && hash_filter_bits == {2{REG_RESET}})
    else $error("registers not cleared by reset");

  reset_read_a: assert property ( // R10
    disable iff (1'b0) rst_in |=> rd_data_out == REG_RESET && !rx_hash_accept_out
    && !receive_logic_enable_out && !hash_filter_enable_out)
    else $error("read port or control bits not cleared by reset");

  // Hash lookups: the answer comes two cycles after the request.
  rx_gate_a: assert property ( // R11
    rx_hash_accept_out |-> $past(receive_logic_enable_out) && $past(rx_hash_valid_in, 2))
    else $error("packet accepted with receive disabled");

  hash_reject_a: assert property ( // R11
    rx_hash_valid_in && !hash_filter_bits[rx_hash_index_in] ##1 hash_filter_enable_out
    |=> !rx_hash_accept_out)
    else $error("packet accepted although its hash bit is clear");

  hash_bypass_a: assert property ( // R11
    rx_hash_valid_in ##1 receive_logic_enable_out && !hash_filter_enable_out
    |=> rx_hash_accept_out)
    else $error("packet refused with hash filtering off");

  ctrl_read_a: assert property ( // R11
    rd_en_in && hit(addr_in, OFS_CONTROL)
    |=> rd_data_out[RECEIVE_LOGIC_ENABLE_BIT] == $past(receive_logic_enable_out))
    else $error("receive enable read answer wrong");

  filter_read_a: assert property ( // R11
    rd_en_in && hit(addr_in, OFS_RX_FILTER)
    |=> rd_data_out[HASH_FILTER_ENABLE_BIT] == $past(hash_filter_enable_out))
    else $error("hash filter enable read answer wrong");

  // ******************************************************************
  // Cover points
  // ******************************************************************
  tx_done_c: cover property (tx_done_in ##[1:4] rd_en_in && hit(addr_in, OFS_TX_START));
  rx_done_c: cover property (rx_done_in ##[1:4] rd_en_in && hit(addr_in, OFS_RX_START));
  rx_accept_c: cover property (hash_filter_enable_out && rx_hash_accept_out);
  reject_c: cover property (hash_filter_enable_out && rx_hash_valid_in ##2 !rx_hash_accept_out);
  back_to_back_c: cover property (wr_en_in ##1 rd_en_in);

endmodule : edph_regs

// *** tb.sv ***
`timescale 1ns/10ps

module tb;
  import edph_pkg::*;

  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [ADDR_W-1:0] addr_in = 8'h00;
  logic [DATA_W-1:0] wr_data_in = 32'h0000_0000;
  logic wr_en_in = 1'b0;
  logic rd_en_in = 1'b0;
  logic tx_done_in = 1'b0;
  logic [DATA_W-1:0] tx_last_descriptor_in = 32'h0000_0000;
  logic rx_done_in = 1'b0;
  logic [DATA_W-1:0] rx_last_descriptor_in = 32'h0000_0000;
  logic rx_hash_valid_in = 1'b0;
  logic [HASH_IDX_W-1:0] rx_hash_index_in = 6'h00;
  logic [DATA_W-1:0] rd_data_out;
  logic [DATA_W-1:0] tx_descriptor_start_out;
  logic [DATA_W-1:0] rx_descriptor_start_out;
  logic receive_logic_enable_out;
  logic hash_filter_enable_out;
  logic rx_hash_accept_out;
  int error_cnt = 0;
  int total_checks = 0;

  edph_regs uut (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .tx_done_in(tx_done_in), .tx_last_descriptor_in(tx_last_descriptor_in),
    .rx_done_in(rx_done_in), .rx_last_descriptor_in(rx_last_descriptor_in),
    .rx_hash_valid_in(rx_hash_valid_in), .rx_hash_index_in(rx_hash_index_in),
    .rd_data_out(rd_data_out), .tx_descriptor_start_out(tx_descriptor_start_out),
    .rx_descriptor_start_out(rx_descriptor_start_out),
    .receive_logic_enable_out(receive_logic_enable_out),
    .hash_filter_enable_out(hash_filter_enable_out), .rx_hash_accept_out(rx_hash_accept_out));

  initial begin
    forever #5 clock_in = ~clock_in;
  end

  // ******************************************************************
  // Bus and check tasks
  // ******************************************************************
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Each bus task returns just past an edge, so results of that edge have landed.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock_in);
    wr_en_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clock_in);
    wr_en_in <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clock_in);
    rd_en_in <= 1'b1;
    addr_in <= a;
    @(posedge clock_in);
    rd_en_in <= 1'b0;
    #1;
    chk(rd_data_out, exp);
  endtask : rd

  // Write, then read the same address back with no idle cycle between strobes.
  task automatic wrrd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic [DATA_W-1:0] exp);
    @(posedge clock_in);
    wr_en_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge clock_in);
    wr_en_in <= 1'b0;
    rd_en_in <= 1'b1;
    @(posedge clock_in);
    rd_en_in <= 1'b0;
    #1;
    chk(rd_data_out, exp);
  endtask : wrrd

  task automatic done(input logic is_tx, input logic [DATA_W-1:0] d);
    @(posedge clock_in);
    tx_done_in <= is_tx;
    rx_done_in <= !is_tx;
    tx_last_descriptor_in <= d;
    rx_last_descriptor_in <= d;
    @(posedge clock_in);
    tx_done_in <= 1'b0;
    rx_done_in <= 1'b0;
    #1;
  endtask : done

  // The answer stands only in the second cycle after the request, then drops.
  task automatic look(input logic [HASH_IDX_W-1:0] i, input logic exp);
    @(posedge clock_in);
    rx_hash_valid_in <= 1'b1;
    rx_hash_index_in <= i;
    @(posedge clock_in);
    rx_hash_valid_in <= 1'b0;
    @(posedge clock_in);
    #1;
    chk({31'h0, rx_hash_accept_out}, {31'h0, exp});
    @(posedge clock_in);
    #1;
    chk({31'h0, rx_hash_accept_out}, 32'h0000_0000);
  endtask : look

  task automatic close_out;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  task automatic do_reset;
    @(posedge clock_in);
    rst_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
  endtask : do_reset

  // ******************************************************************
  // Test sequence
  // ******************************************************************
  initial begin
    do_reset();
    for (int k = 0; k < 6; k++) rd(8'(4 * k), REG_RESET);
    chk(tx_descriptor_start_out | rx_descriptor_start_out, REG_RESET);
    wr(OFS_TX_START, 32'hFFFF_FFFF);
    chk(tx_descriptor_start_out, 32'hFFFF_FFFC);
    rd(OFS_TX_START, 32'hFFFF_FFFC);
    wr(OFS_RX_START, 32'h8765_4323);
    chk(rx_descriptor_start_out, 32'h8765_4320);
    rd(OFS_RX_START, 32'h8765_4320);
    rd(OFS_TX_START, 32'hFFFF_FFFC);
    wrrd(OFS_HASH_LOW, 32'hA5A5_5A5A, 32'hA5A5_5A5A);
    wr(8'h20, 32'h1234_5678);
    rd(8'h20, 32'h0000_0000);
    done(1'b1, 32'h1000_0013);
    chk(tx_descriptor_start_out, 32'h1000_0010);
    chk(rx_descriptor_start_out, 32'h8765_4320);
    rd(OFS_TX_START, 32'h1000_0010);
    done(1'b0, 32'h2000_0027);
    chk(rx_descriptor_start_out, 32'h2000_0024);
    chk(tx_descriptor_start_out, 32'h1000_0010);
    rd(OFS_RX_START, 32'h2000_0024);
    wr(OFS_TX_START, 32'h0000_4000);
    chk(tx_descriptor_start_out, 32'h0000_4000);
    wr(OFS_HASH_LOW, 32'h0000_0008);
    wrrd(OFS_HASH_HIGH, 32'h0000_0001, 32'h0000_0001);
    look(6'd3, 1'b0);
    wr(OFS_CONTROL, 32'h0000_0100);
    chk({31'h0, receive_logic_enable_out}, 32'h0000_0001);
    look(6'd4, 1'b1);
    wr(OFS_RX_FILTER, 32'h0000_8000);
    chk({31'h0, hash_filter_enable_out}, 32'h0000_0001);
    look(6'd3, 1'b1);
    look(6'd4, 1'b0);
    look(6'd32, 1'b1);
    look(6'd33, 1'b0);
    wr(OFS_CONTROL, 32'h0000_0000);
    look(6'd3, 1'b0);
    do_reset();
    #1;
    chk(tx_descriptor_start_out | rx_descriptor_start_out, REG_RESET);
    rd(OFS_HASH_LOW, REG_RESET);
    rd(OFS_RX_FILTER, REG_RESET);
    close_out();
  end

  initial begin
    #20000;
    error_cnt++;
    close_out();
  end

endmodule : tb
